// ---- hw/cec_consts.svh ----
// Summary of operation
// RULE1 - Window reference picks one of twelve dead-centre values.
// RULE2 - Cam A window ends at configurable angle, default -60.
// RULE3 - Cam A rising edge in window records angle.
// RULE4 - Cam B has its own independent window.
// RULE5 - Cam B edge angle reported from its window.
// RULE6 - Sampler records every tracking input level.
// RULE7 - Count pulses or edges between two cursors.
// RULE8 - Start begins acquisition; second start aborts it.
// RULE9 - Buffer-full flag when samples are lost.
// RULE10 - Sync status shown; clear resets latched errors. Clear drops only the sticky sync-loss bit, not the buffer-full flag.
// RULE11 - Fixed mode stops after configured sample count.
// RULE12 - Sync-loss mode wraps buffer until sync lost.
// RULE13 - No edge in window keeps previous angle.
`ifndef CEC_CONSTS_SVH
`define CEC_CONSTS_SVH
// ---------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------
`define CEC_R_CTRL     8'h00
`define CEC_R_REFSEL   8'h04
`define CEC_R_A_START  8'h08
`define CEC_R_A_END    8'h0C
`define CEC_R_B_START  8'h10
`define CEC_R_B_END    8'h14
`define CEC_R_A_ANGLE  8'h18
`define CEC_R_B_ANGLE  8'h1C
`define CEC_R_NSAMP    8'h20
`define CEC_R_CUR1     8'h24
`define CEC_R_CUR2     8'h28
`define CEC_R_CNTSEL   8'h2C
`define CEC_R_STATUS   8'h30
`define CEC_R_COUNT    8'h34
`define CEC_R_IRQ_STAT 8'h38
`define CEC_R_IRQ_EN   8'h3C
`define CEC_R_IRQ_CLR  8'h40
`define CEC_R_SMP_DATA 8'h44
`define CEC_R_SMP_IDX  8'h48
`define CEC_R_TDC_BASE 8'h80
// ---------------------------------------------------------------
// Field positions and reset values.
// ---------------------------------------------------------------
`define CEC_CTRL_START  0
`define CEC_CTRL_MODE   1
`define CEC_CTRL_CLR    2
`define CEC_PIN_SYNC    0
`define CEC_PIN_CAM_A   3
`define CEC_PIN_CAM_B   4
`define CEC_A_START_RST 16'h003C
`define CEC_A_END_RST   16'hFFC4
`define CEC_NSAMP_RST   32'h0002_3280
`define CEC_CYC_DEG     18'h002D0
`define CEC_HALF_DEG    18'h00168
`define CEC_NUM_TDC     12
`define CEC_NUM_IRQ     5
`define CEC_IRQ_A       0
`define CEC_IRQ_B       1
`define CEC_IRQ_DONE    2
`define CEC_IRQ_FULL    3
`define CEC_IRQ_SYNC    4
`endif

// ---- hw/cec_pkg.sv ----
package cec_pkg;
  // Levels of the tracking inputs, bit 7 first.
  typedef struct packed {
    logic masked_index;
    logic ext_cam;
    logic offset_cam;
    logic cam_b;
    logic cam_a;
    logic enc_index;
    logic crank;
    logic sync;
  } cec_pins_t;
  // Kind of event that the cursor counter counts.
  typedef enum logic [1:0] {
    CEC_CNT_PULSE,
    CEC_CNT_RISE,
    CEC_CNT_FALL
  } cec_cnt_kind_t;
  // Sampler acquisition modes.
  typedef enum logic {
    CEC_MODE_FIXED,
    CEC_MODE_SYNC
  } cec_mode_t;
endpackage : cec_pkg

// ---- hw/cec_sample_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
// Simple dual-port sample store with registered read data.
module cec_sample_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 144000,
  parameter int AW    = 18
) (
  input  wire logic          i_clk,
  input  wire logic          i_ce,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata_q
);
  logic [W-1:0] mem [DEPTH]; // Storage array.

  // Write port.
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port.
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_rdata_q <= mem[i_raddr];
    end
  end
endmodule : cec_sample_mem
`default_nettype wire

// ---- hw/cec_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cec_consts.svh"
// Cam edge capture and tracking-input sampler.
module cec_top #(
  parameter int DEPTH = 144000, // Sample store depth.
  parameter int AW    = 18      // Sample address width.
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire cec_pkg::cec_pins_t i_pins,
  input  wire logic [15:0]       i_crank_angle,
  input  wire logic              i_sample_tick,
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata_q,
  output logic                   o_irq_q,
  output logic                   o_sync_q,
  output logic                   o_running_q
);
  import cec_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  cec_pins_t pin_m_q;  // First stage, read only by the second.
  cec_pins_t pin_s_q;  // Second stage, safe to use.
  cec_pins_t pin_p_q;  // Previous value for edge detection.

  // Two flip-flops bring the sensor pins into the clock domain.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
    end else if (i_ce) begin
      pin_m_q <= i_pins;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------
  logic [15:0] tdc_q [`CEC_NUM_TDC]; // Dead-centre references.
  logic [3:0]  ref_sel_q;             // Chosen reference index.
  logic [15:0] a_start_q;             // Cam A window start.
  logic [15:0] a_end_q;               // Cam A window end.
  logic [15:0] b_start_q;             // Cam B window start.
  logic [15:0] b_end_q;               // Cam B window end.
  logic [31:0] nsamp_q;               // Fixed mode sample count.
  logic [31:0] cur1_q;                // First cursor sample.
  logic [31:0] cur2_q;                // Second cursor sample.
  logic [2:0]  cnt_sig_q;             // Counted pin index.
  logic [1:0]  cnt_kind_q;            // Counted event kind.
  cec_mode_t   mode_q;                // Acquisition mode.
  logic [AW-1:0] rd_idx_q;            // Sample readback index.
  logic [`CEC_NUM_IRQ-1:0] irq_en_q;  // Interrupt enables.
  logic        wr_ctrl;               // Write to control.

  assign wr_ctrl = i_wr && (i_addr == `CEC_R_CTRL);

  // Software writes to the configuration registers.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < `CEC_NUM_TDC; k++) begin
        tdc_q[k] <= '0;
      end
      ref_sel_q  <= '0;
      a_start_q  <= `CEC_A_START_RST;
      a_end_q    <= `CEC_A_END_RST; // RULE2
      b_start_q  <= `CEC_A_START_RST;
      b_end_q    <= `CEC_A_END_RST;
      nsamp_q    <= `CEC_NSAMP_RST;
      cur1_q     <= '0;
      cur2_q     <= '0;
      cnt_sig_q  <= '0;
      cnt_kind_q <= '0;
      mode_q     <= CEC_MODE_FIXED;
      rd_idx_q   <= '0;
      irq_en_q   <= '0;
    end else if (i_ce && i_wr) begin
      // Twelve references sit in consecutive words.
      for (int k = 0; k < `CEC_NUM_TDC; k++) begin
        if (i_addr == `CEC_R_TDC_BASE + 8'(4 * k)) begin
          tdc_q[k] <= i_wdata[15:0];
        end
      end
      unique case (i_addr)
        `CEC_R_CTRL: begin
          mode_q <= cec_mode_t'(i_wdata[`CEC_CTRL_MODE]);
        end
        `CEC_R_REFSEL:  ref_sel_q <= i_wdata[3:0]; // RULE1
        `CEC_R_A_START: a_start_q <= i_wdata[15:0];
        `CEC_R_A_END:   a_end_q   <= i_wdata[15:0]; // RULE2
        `CEC_R_B_START: b_start_q <= i_wdata[15:0]; // RULE4
        `CEC_R_B_END:   b_end_q   <= i_wdata[15:0]; // RULE4
        `CEC_R_NSAMP:   nsamp_q   <= i_wdata;
        `CEC_R_CUR1:    cur1_q    <= i_wdata;
        `CEC_R_CUR2:    cur2_q    <= i_wdata;
        `CEC_R_CNTSEL: begin
          cnt_sig_q  <= i_wdata[2:0];
          cnt_kind_q <= i_wdata[5:4];
        end
        `CEC_R_SMP_IDX: rd_idx_q <= i_wdata[AW-1:0];
        `CEC_R_IRQ_EN:  irq_en_q <= i_wdata[`CEC_NUM_IRQ-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Angle arithmetic.
  // ---------------------------------------------------------------
  // Degrees before the reference, folded into one half cycle.
  function automatic logic signed [17:0] before_ref(
    input logic [15:0] ref_ang,
    input logic [15:0] ang
  );
    logic signed [17:0] d;
    d = signed'({2'b00, ref_ang}) - signed'({2'b00, ang});
    if (d > signed'(`CEC_HALF_DEG)) begin
      d = d - signed'(`CEC_CYC_DEG);
    end else if (d < -signed'(`CEC_HALF_DEG)) begin
      d = d + signed'(`CEC_CYC_DEG);
    end
    return d;
  endfunction : before_ref

  logic signed [17:0] degrees_before_dead_centre;  // Crank angle before reference.
  logic               a_in;   // Crank is inside window A.
  logic               b_in;   // Crank is inside window B.
  logic [15:0]        sel_ref; // Selected reference.

  // Only one reference at a time steers both windows.
  assign sel_ref = (ref_sel_q < 4'(`CEC_NUM_TDC)) ?
                   tdc_q[ref_sel_q] : tdc_q[0]; // RULE1
  assign degrees_before_dead_centre = before_ref(sel_ref, i_crank_angle);
  // Start lies further before the reference than end.
  assign a_in = (degrees_before_dead_centre <= signed'(18'(signed'(a_start_q)))) &&
                (degrees_before_dead_centre >= signed'(18'(signed'(a_end_q))));
  assign b_in = (degrees_before_dead_centre <= signed'(18'(signed'(b_start_q)))) &&
                (degrees_before_dead_centre >= signed'(18'(signed'(b_end_q)))); // RULE4

  // ---------------------------------------------------------------
  // Cam edge capture.
  // ---------------------------------------------------------------
  logic [15:0] a_angle_q; // Last cam A edge angle.
  logic [15:0] b_angle_q; // Last cam B edge angle.
  logic        a_armed_q; // Window A still waits for its edge.
  logic        b_armed_q; // Window B still waits for its edge.
  logic        a_rise;    // Cam A rising edge.
  logic        b_rise;    // Cam B rising edge.
  logic        a_hit;     // Cam A capture event.
  logic        b_hit;     // Cam B capture event.

  assign a_rise = pin_s_q.cam_a && !pin_p_q.cam_a;
  assign b_rise = pin_s_q.cam_b && !pin_p_q.cam_b;
  assign a_hit  = a_rise && a_in && a_armed_q; // RULE3
  assign b_hit  = b_rise && b_in && b_armed_q; // RULE4

  // First edge in each window is latched; arms re-open outside.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      a_angle_q <= '0;
      b_angle_q <= '0;
      a_armed_q <= 1'b1;
      b_armed_q <= 1'b1;
    end else if (i_ce) begin
      if (a_hit) begin
        a_angle_q <= degrees_before_dead_centre[15:0]; // RULE3
        a_armed_q <= 1'b0;
      end else if (!a_in) begin
        a_armed_q <= 1'b1; // RULE13
      end
      if (b_hit) begin
        b_angle_q <= degrees_before_dead_centre[15:0]; // RULE5
        b_armed_q <= 1'b0;
      end else if (!b_in) begin
        b_armed_q <= 1'b1; // RULE13
      end
    end
  end

  // ---------------------------------------------------------------
  // Sampler control.
  // ---------------------------------------------------------------
  typedef enum logic {CEC_ST_IDLE, CEC_ST_RUN} cec_state_t;
  cec_state_t    state_q;  // Acquisition state.
  logic [31:0]   taken_q;  // Samples taken this run.
  logic [AW-1:0] wptr_q;   // Next store address.
  logic          full_q;   // Samples were lost.
  logic          start;    // Start command pulse.
  logic          sync_fall; // Synchronisation lost.
  logic          store;    // A sample is stored now.
  logic          done;     // Acquisition ends now.

  assign start     = wr_ctrl && i_wdata[`CEC_CTRL_START];
  assign sync_fall = !pin_s_q.sync && pin_p_q.sync;
  assign store     = (state_q == CEC_ST_RUN) && i_sample_tick;
  assign done = (state_q == CEC_ST_RUN) && !start &&
    (((mode_q == CEC_MODE_FIXED) && store &&
      (taken_q + 32'h1 >= nsamp_q)) ||               // RULE11
     ((mode_q == CEC_MODE_SYNC) && sync_fall));      // RULE12

  // Start enters acquisition; a second start aborts it.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= CEC_ST_IDLE;
    end else if (i_ce) begin
      unique case (state_q)
        CEC_ST_IDLE: begin
          if (start) begin
            state_q <= CEC_ST_RUN; // RULE8
          end
        end
        CEC_ST_RUN: begin
          if (start || done) begin
            state_q <= CEC_ST_IDLE; // RULE8
          end
        end
      endcase
    end
  end

  // Store pointer, count and overflow flag.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      taken_q <= '0;
      wptr_q  <= '0;
      full_q  <= 1'b0;
    end else if (i_ce) begin
      if (start && state_q == CEC_ST_IDLE) begin
        taken_q <= '0;
        wptr_q  <= '0;
        full_q  <= 1'b0;
      end else if (store) begin
        taken_q <= taken_q + 32'h1;
        if (wptr_q == AW'(DEPTH - 1)) begin
          // Sync mode purges the oldest; fixed mode loses data.
          wptr_q <= '0; // RULE12
          if (mode_q == CEC_MODE_FIXED) begin
            full_q <= 1'b1; // RULE9
          end
        end else begin
          wptr_q <= wptr_q + AW'(1);
        end
      end
    end
  end

  logic [7:0]  smp_rdata;  // Sample read back.

  // Every tracking input level goes into the store.
  cec_sample_mem #(
    .W     ($bits(cec_pins_t)),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .i_clk     (i_clk),
    .i_ce      (i_ce),
    .i_we      (store),
    .i_waddr   (wptr_q),
    .i_wdata   (pin_s_q), // RULE6
    .i_raddr   (rd_idx_q),
    .o_rdata_q (smp_rdata)
  );

  // ---------------------------------------------------------------
  // Cursor edge counter.
  // ---------------------------------------------------------------
  logic [31:0] count_q;    // Events between cursors.
  logic        last_q;     // Previous stored level.
  logic        rose_q;     // A rise seen inside range.
  logic        cur_bit;    // Counted pin level now.
  logic        in_range;   // Sample index between cursors.

  assign cur_bit  = pin_s_q[cnt_sig_q];
  assign in_range = (taken_q > cur1_q) && (taken_q <= cur2_q);

  // Counts pulses, rises or falls among stored samples.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= '0;
      last_q  <= 1'b0;
      rose_q  <= 1'b0;
    end else if (i_ce) begin
      if (start && state_q == CEC_ST_IDLE) begin
        count_q <= '0;
        rose_q  <= 1'b0;
      end else if (store) begin
        last_q <= cur_bit;
        if (in_range) begin
          if (cur_bit && !last_q) begin
            rose_q <= 1'b1;
          end
          unique case (cec_cnt_kind_t'(cnt_kind_q))
            CEC_CNT_RISE: begin
              if (cur_bit && !last_q) begin
                count_q <= count_q + 32'h1; // RULE7
              end
            end
            CEC_CNT_FALL: begin
              if (!cur_bit && last_q) begin
                count_q <= count_q + 32'h1; // RULE7
              end
            end
            CEC_CNT_PULSE: begin
              // A pulse is a rise followed by its fall.
              if (!cur_bit && last_q && rose_q) begin
                count_q <= count_q + 32'h1; // RULE7
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts and status outputs.
  // ---------------------------------------------------------------
  logic [`CEC_NUM_IRQ-1:0] irq_st_q;  // Sticky events.
  logic [`CEC_NUM_IRQ-1:0] irq_set;   // Events this cycle.
  logic [`CEC_NUM_IRQ-1:0] irq_clr;   // Software clears.

  always_comb begin
    irq_set = '0;
    irq_set[`CEC_IRQ_A]    = a_hit;
    irq_set[`CEC_IRQ_B]    = b_hit;
    irq_set[`CEC_IRQ_DONE] = done;
    irq_set[`CEC_IRQ_FULL] = store && !full_q &&
      (mode_q == CEC_MODE_FIXED) && (wptr_q == AW'(DEPTH - 1));
    irq_set[`CEC_IRQ_SYNC] = sync_fall;
    irq_clr = '0;
    if (i_wr && i_addr == `CEC_R_IRQ_CLR) begin
      irq_clr = i_wdata[`CEC_NUM_IRQ-1:0];
    end
    // Clear command in control also drops the sync error.
    if (wr_ctrl && i_wdata[`CEC_CTRL_CLR]) begin
      irq_clr[`CEC_IRQ_SYNC] = 1'b1; // RULE10
    end
  end

  // Sticky bits; a new event wins over a clear.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_st_q <= '0;
    end else if (i_ce) begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set; // RULE10
    end
  end

  // Registered interrupt, sync and running outputs.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_q     <= 1'b0;
      o_sync_q    <= 1'b0;
      o_running_q <= 1'b0;
    end else if (i_ce) begin
      o_irq_q     <= |(((irq_st_q & ~irq_clr) | irq_set) & irq_en_q);
      o_sync_q    <= pin_s_q.sync; // RULE10
      o_running_q <= (state_q == CEC_ST_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Register read port.
  // ---------------------------------------------------------------
  // Read data stand in the cycle after the read strobe.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata_q <= '0;
    end else if (i_ce) begin
      o_rdata_q <= '0;
      if (i_rd) begin
        for (int k = 0; k < `CEC_NUM_TDC; k++) begin
          if (i_addr == `CEC_R_TDC_BASE + 8'(4 * k)) begin
            o_rdata_q <= {16'h0000, tdc_q[k]};
          end
        end
        unique case (i_addr)
          `CEC_R_CTRL:    o_rdata_q <= {30'h0, mode_q, 1'b0};
          `CEC_R_REFSEL:  o_rdata_q <= {28'h0, ref_sel_q};
          `CEC_R_A_START: o_rdata_q <= {16'h0000, a_start_q};
          `CEC_R_A_END:   o_rdata_q <= {16'h0000, a_end_q};
          `CEC_R_B_START: o_rdata_q <= {16'h0000, b_start_q};
          `CEC_R_B_END:   o_rdata_q <= {16'h0000, b_end_q};
          `CEC_R_A_ANGLE: o_rdata_q <= {16'h0000, a_angle_q}; // RULE3
          `CEC_R_B_ANGLE: o_rdata_q <= {16'h0000, b_angle_q}; // RULE5
          `CEC_R_NSAMP:   o_rdata_q <= nsamp_q;
          `CEC_R_CUR1:    o_rdata_q <= cur1_q;
          `CEC_R_CUR2:    o_rdata_q <= cur2_q;
          `CEC_R_CNTSEL:  o_rdata_q <= {26'h0, cnt_kind_q, 1'b0, cnt_sig_q};
          `CEC_R_STATUS: begin
            o_rdata_q <= {29'h0, full_q, pin_s_q.sync,
                          state_q == CEC_ST_RUN}; // RULE9
          end
          `CEC_R_COUNT:    o_rdata_q <= count_q; // RULE7
          `CEC_R_IRQ_STAT: o_rdata_q <= 32'(irq_st_q);
          `CEC_R_IRQ_EN:   o_rdata_q <= 32'(irq_en_q);
          `CEC_R_SMP_DATA: o_rdata_q <= {24'h0, smp_rdata};
          `CEC_R_SMP_IDX:  o_rdata_q <= 32'(rd_idx_q);
          default: ;
        endcase
      end
    end
  end
endmodule : cec_top
`default_nettype wire

// ---- dv/cec_sensor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Crank and cam sensor stand-in: angle runs 0 to 719, one cam pulse a turn.
module cec_sensor_model (
  input  wire logic           i_clk,
  input  wire logic           i_run,
  input  wire logic [7:0]     i_pat,
  input  wire logic [15:0]    i_a_at,
  input  wire logic [15:0]    i_b_at,
  output var cec_pkg::cec_pins_t o_pins,
  output logic      [15:0]    o_angle
);
  import cec_pkg::*;
  // The angle steps one degree a cycle while the engine turns.
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      o_angle <= 16'h0000;
    end else begin
      o_angle <= (o_angle == 16'h02CF) ? 16'h0000 : o_angle + 16'h0001;
    end
  end
  // A stopped engine shows the static pattern; a turning one adds crank and cams.
  always_comb begin
    o_pins = i_pat;
    if (i_run) begin
      o_pins.crank = o_angle[1];
      o_pins.cam_a = (o_angle >= i_a_at) && (o_angle < i_a_at + 16'h0014);
      o_pins.cam_b = (o_angle >= i_b_at) && (o_angle < i_b_at + 16'h0014);
    end
  end
endmodule : cec_sensor_model
`default_nettype wire

// ---- dv/cec_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the capture and sampler block.
module cec_top_assertions (
  input wire logic               i_clk,
  input wire logic               i_sys_rst,
  input wire logic               i_ce,
  input wire cec_pkg::cec_pins_t i_pins,
  input wire logic [7:0]         i_addr,
  input wire logic [31:0]        i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [31:0]        o_rdata_q,
  input wire logic               o_irq_q,
  input wire logic               o_sync_q,
  input wire logic               o_running_q
);
  import cec_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic  st = i_ce && i_wr && (i_addr == 8'h00) && i_wdata[0]; // Start command.
  logic [2:0] age_q; // Cycles since reset, saturating.
  // Age counter keeps the sync check away from the pipeline fill.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  sequence s_start;
    st && !o_running_q && !$past(st) ##1 i_ce;
  endsequence
  sequence s_abort;
    st && o_running_q ##1 i_ce;
  endsequence
  chk_run_start: assert property (s_start |-> ##1 o_running_q)
    else $error("start did not raise running");
  chk_run_abort: assert property (s_abort |-> ##1 !o_running_q)
    else $error("second start did not abort");
  chk_run_cause: assert property ($rose(o_running_q) |-> $past(st, 2))
    else $error("running rose without start");
  chk_sync_follow: assert property (($stable(i_pins.sync) [*4]) ##0 age_q == 3'h7
    |-> o_sync_q == i_pins.sync) else $error("sync status differs from pin");
  chk_reset_quiet: assert property ($fell(i_sys_rst) |->
    !o_running_q && !o_irq_q && !o_sync_q && o_rdata_q == 32'h0) else $error("output after reset");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata_q == 32'h0)
    else $error("read data outside read cycle");
  chk_clr_reads_zero: assert property (i_ce && i_rd && i_addr == 8'h40 |=> o_rdata_q == 32'h0)
    else $error("clear register read not zero");
  chk_irq_mask: assert property (i_ce && i_wr && i_addr == 8'h3C && i_wdata[4:0] == 5'h00
    |=> ##1 !o_irq_q) else $error("masked interrupt still high");
  chk_ce_freeze: assert property (!i_ce |=> $stable(o_running_q) && $stable(o_irq_q))
    else $error("state moved with enable low");
endmodule : cec_top_assertions
bind cec_top cec_top_assertions u_chk (.i_clk, .i_sys_rst, .i_ce, .i_pins, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata_q, .o_irq_q, .o_sync_q, .o_running_q);
`default_nettype wire

// ---- dv/cec_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cec_consts.svh"
// Self-checking bench: sensor model on the pins, register port from tasks.
module cec_top_tb_top;
  import cec_pkg::*;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_sample_tick = 1'b0;
  logic        i_wr = 1'b0, i_rd = 1'b0, run = 1'b0;
  logic [7:0]  i_addr = 8'h00, pat = 8'h01;
  logic [31:0] i_wdata = 32'h0, q;
  logic [15:0] a_at = 16'h00AA, b_at = 16'h00E6, i_crank_angle;
  cec_pins_t   i_pins;
  logic [31:0] o_rdata_q;
  logic        o_irq_q, o_sync_q, o_running_q;
  int          num_errors = 0, tests_run = 0;
  always #2.5 i_clk = ~i_clk;
  cec_top #(.DEPTH(16), .AW(4)) dut (.i_clk, .i_sys_rst, .i_ce, .i_pins, .i_crank_angle,
    .i_sample_tick, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_q, .o_irq_q, .o_sync_q,
    .o_running_q);
  cec_sensor_model u_sns (.i_clk, .i_run(run), .i_pat(pat), .i_a_at(a_at), .i_b_at(b_at),
    .o_pins(i_pins), .o_angle(i_crank_angle));
  task automatic end_sim;
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 q = o_rdata_q;
  endtask : rd
  // Reads a register and compares the whole word or its low angle half.
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e, input bit lo);
    rd(a);
    chk(n, lo ? {16'h0, q[15:0]} : q, e);
  endtask : rc
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_sample_tick <= 1'b1;
      @(posedge i_clk);
      i_sample_tick <= 1'b0;
    end
  endtask : tk
  task automatic setp(input logic [7:0] p);
    @(posedge i_clk);
    pat <= p;
    repeat (4) @(posedge i_clk);
  endtask : setp
  // Bounded wait for the acquisition to end.
  task automatic wt;
    for (int k = 0; k < 20 && o_running_q !== 1'b0; k++) @(posedge i_clk);
    chk("running", {31'h0, o_running_q}, 32'h0);
  endtask : wt
  task automatic t_regs;
    rc("a_start", `CEC_R_A_START, 32'h003C, 1);
    rc("a_end", `CEC_R_A_END, 32'hFFC4, 1);
    rc("nsamp", `CEC_R_NSAMP, 32'h0002_3280, 0);
    rc("unmapped", 8'h4C, 32'h0, 0);
  endtask : t_regs
  // Two turns: both cams hit their windows the first time, both miss them the second time.
  task automatic t_cap;
    wr(`CEC_R_TDC_BASE + 8'h14, 32'h00C8);
    wr(`CEC_R_REFSEL, 32'h5);
    wr(`CEC_R_B_START, 32'hFFFF_FFEC);
    wr(`CEC_R_B_END, 32'hFFFF_FFD8);
    run <= 1'b1;
    repeat (800) @(posedge i_clk);
    rc("a_angle", `CEC_R_A_ANGLE, 32'h001C, 1);
    rc("b_angle", `CEC_R_B_ANGLE, 32'hFFE0, 1);
    a_at <= 16'h0190;
    b_at <= 16'h00AA;
    repeat (800) @(posedge i_clk);
    rc("a_keep", `CEC_R_A_ANGLE, 32'h001C, 1);
    rc("b_keep", `CEC_R_B_ANGLE, 32'hFFE0, 1);
    run <= 1'b0;
  endtask : t_cap
  task automatic t_irq;
    rc("irq_stat", `CEC_R_IRQ_STAT, 32'h3, 0);
    wr(`CEC_R_IRQ_EN, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq_on", {31'h0, o_irq_q}, 32'h1);
    wr(`CEC_R_IRQ_EN, 32'h0);
    repeat (2) @(posedge i_clk);
    chk("irq_masked", {31'h0, o_irq_q}, 32'h0);
    wr(`CEC_R_IRQ_CLR, 32'h1F);
    rc("irq_clr", `CEC_R_IRQ_STAT, 32'h0, 0);
    rc("clr_read", `CEC_R_IRQ_CLR, 32'h0, 0);
  endtask : t_irq
  // Fixed run of five samples with an ignored tick while the enable is low.
  task automatic t_fixed;
    setp(8'hA5);
    wr(`CEC_R_NSAMP, 32'h5);
    wr(`CEC_R_CTRL, 32'h1);
    tk(4);
    i_ce <= 1'b0;
    tk(1);
    i_ce <= 1'b1;
    rc("still_run", `CEC_R_STATUS, 32'h3, 0);
    tk(1);
    wt;
    rc("done_irq", `CEC_R_IRQ_STAT, 32'h4, 0);
    wr(`CEC_R_SMP_IDX, 32'h2);
    repeat (2) @(posedge i_clk);
    rd(`CEC_R_SMP_DATA);
    chk("sample", {24'h0, q[7:0]}, 32'hA5);
  endtask : t_fixed
  task automatic t_full;
    wr(`CEC_R_NSAMP, 32'h14);
    wr(`CEC_R_CTRL, 32'h1);
    tk(20);
    wt;
    rc("full", `CEC_R_STATUS, 32'h6, 0);
  endtask : t_full
  task automatic t_abort;
    wr(`CEC_R_IRQ_CLR, 32'h1F);
    wr(`CEC_R_CTRL, 32'h1);
    tk(3);
    wr(`CEC_R_CTRL, 32'h1);
    wt;
    rc("abort_irq", `CEC_R_IRQ_STAT, 32'h0, 0);
    rc("full_clr", `CEC_R_STATUS, 32'h2, 0);
  endtask : t_abort
  task automatic t_sync;
    wr(`CEC_R_CTRL, 32'h3);
    tk(20);
    rc("wrap_run", `CEC_R_STATUS, 32'h3, 0);
    setp(8'hA4);
    wt;
    rd(`CEC_R_IRQ_STAT);
    chk("sync_lost", {31'h0, q[4]}, 32'h1);
    setp(8'hA5);
    wr(`CEC_R_CTRL, 32'h4);
    rd(`CEC_R_IRQ_STAT);
    chk("sync_clr", {31'h0, q[4]}, 32'h0);
  endtask : t_sync
  // Crank toggles each sample; samples four to eight hold 2 rises and 3 falls.
  task automatic t_count;
    logic [31:0] exp [3] = '{32'h2, 32'h2, 32'h3};
    for (int k = 0; k < 3; k++) begin
      wr(`CEC_R_CNTSEL, 32'h1 | (k << 4));
      wr(`CEC_R_CUR1, 32'h2);
      wr(`CEC_R_CUR2, 32'h7);
      wr(`CEC_R_NSAMP, 32'hA);
      wr(`CEC_R_CTRL, 32'h1);
      for (int i = 1; i <= 10; i++) begin
        setp({6'h0, i[0], 1'b1});
        tk(1);
      end
      wt;
      rc("count", `CEC_R_COUNT, exp[k], 0);
    end
  endtask : t_count
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_regs;
    t_cap;
    t_irq;
    t_fixed;
    t_full;
    t_abort;
    t_sync;
    t_count;
    end_sim;
  end
  // Watchdog well beyond the roughly 2,000 cycles the scenarios need.
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
endmodule : cec_top_tb_top
`default_nettype wire
